// file: logic/pofm_defines.svh
// Timing figures and derived cycle counts for the probe overload and fault monitor.
// Assumes core_clk runs at the period given by POFM_CLK_NS.
`ifndef POFM_DEFINES_SVH
`define POFM_DEFINES_SVH

// ----------------------------------------------------------------
// Clock
// ----------------------------------------------------------------
`define POFM_CLK_NS        10

// ----------------------------------------------------------------
// Minimum and limit times in ns
// ----------------------------------------------------------------
`define POFM_HALF_MIN_NS   280
`define POFM_PER_MIN_NS    275
`define POFM_LOW_MAX_NS    32000
`define POFM_WIRE_MIN_NS   100000

// ----------------------------------------------------------------
// Cycle counts: least times round up, longest times round down
// ----------------------------------------------------------------
`define POFM_HALF_MIN_CYC  ((`POFM_HALF_MIN_NS + `POFM_CLK_NS - 1) / `POFM_CLK_NS)
`define POFM_PER_MIN_CYC   ((`POFM_PER_MIN_NS + `POFM_CLK_NS - 1) / `POFM_CLK_NS)
`define POFM_LOW_MAX_CYC   (`POFM_LOW_MAX_NS / `POFM_CLK_NS)
`define POFM_WIRE_MIN_CYC  ((`POFM_WIRE_MIN_NS + `POFM_CLK_NS - 1) / `POFM_CLK_NS)

// Consecutive event count that trips latch or fault
`define POFM_REPEAT_CNT    3

`endif

// file: logic/pofm_monitor.sv
// Probe oscillation supervisor: overload latch, probe and coil faults, PWM pair.
// Assumes comparator and control pins are asynchronous; comp_dir is on core_clk.
//
// Behaviour
// - Three consecutive same-polarity halves under 280 ns enter overload latch.
// - No probe half-period may end before 280 ns.
// - In overload latch, hold stored compensation polarity, keep producing PWM.
// - Leave overload latch once both half-periods exceed 280 ns again.
// - Comparator low over 32 us raises error and zeroes compensation command.
// - Comparator period under 275 ns three times running raises error.
// - Near-ground drive with low coil current for 100 us raises error.
// - Coil-check enable low disables the wire-break check.
// - Gain-select high reduces internal loop gain about 8 dB.
// - Probe state appears on a complementary PWM output pair.
// - Error releases by itself once the fault has gone.
`timescale 1ns/1ps
`include "pofm_defines.svh"

module pofm_monitor
  import pofm_pkg::*;
#(
  parameter int WIRE_MIN_CYC = `POFM_WIRE_MIN_CYC
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic probe_comparator_out,
  input  wire logic comp_near_gnd_a,
  input  wire logic comp_near_gnd_b,
  input  wire logic coil_current_ok,
  input  wire logic coil_check_enable,
  input  wire logic gain_select,
  input  wire logic comp_dir,
  input  wire logic error_pin_i,
  output logic      probe_drive,
  output logic      pwm_out,
  output logic      pwm_out_n,
  output logic      overload_latch,
  output logic      comp_polarity,
  output logic      comp_enable,
  output logic      gain_reduce,
  output logic      error_pin_o,
  output logic      error_pin_oe_n
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0]  rst_sync_r;
  logic        rst_n;
  logic [4:0]  pins_s;
  logic        trip_s;
  logic        near_s;
  logic        cur_ok_s;
  logic        chk_s;
  logic        gain_s;
  pofm_state_t st_r;
  pofm_state_t st_nxt;

  // Assert at once, release after two edges
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  pofm_sync #(.WIDTH(5)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .d        ({probe_comparator_out, comp_near_gnd_a | comp_near_gnd_b,
                coil_current_ok, coil_check_enable, gain_select}),
    .q        (pins_s)
  );
  assign {trip_s, near_s, cur_ok_s, chk_s, gain_s} = pins_s;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic half_end;
  logic trip_rise;
  logic stuck;
  logic fast;
  logic wire_brk;

  always_comb begin
    st_nxt   = st_r;
    trip_rise = trip_s && !st_r.trip_d;
    stuck    = st_r.low_cnt > 12'(`POFM_LOW_MAX_CYC);
    fast     = st_r.fast_cnt == 2'(`POFM_REPEAT_CNT);
    wire_brk = st_r.wire_cnt == 14'(WIRE_MIN_CYC);
    // Half ends only after the minimum; an early trip is held pending
    half_end = (trip_rise || st_r.cur_short) &&
               (st_r.hcnt >= 8'(`POFM_HALF_MIN_CYC - 1));
    st_nxt.trip_d = trip_s;

    // Half-period timing and short-half bookkeeping
    if (half_end) begin
      st_nxt.drive_pol = !st_r.drive_pol;
      st_nxt.hcnt      = 8'h00;
      st_nxt.cur_short = 1'b0;
      if (st_r.drive_pol) begin
        st_nxt.short_cnt1   = st_r.cur_short ?
            st_r.short_cnt1 + (st_r.short_cnt1 != 2'h3 ? 2'h1 : 2'h0) : 2'h0;
        st_nxt.long_seen[1] = !st_r.cur_short;
      end else begin
        st_nxt.short_cnt0   = st_r.cur_short ?
            st_r.short_cnt0 + (st_r.short_cnt0 != 2'h3 ? 2'h1 : 2'h0) : 2'h0;
        st_nxt.long_seen[0] = !st_r.cur_short;
      end
    end else begin
      if (st_r.hcnt != 8'hFF) begin
        st_nxt.hcnt = st_r.hcnt + 8'h01;
      end
      if (trip_rise) begin
        st_nxt.cur_short = 1'b1;
      end
    end

    // Overload latch; entry captures polarity so it survives saturation
    if (!st_r.ovl) begin
      if (st_nxt.short_cnt0 == 2'(`POFM_REPEAT_CNT) ||
          st_nxt.short_cnt1 == 2'(`POFM_REPEAT_CNT)) begin
        st_nxt.ovl       = 1'b1;
        st_nxt.held_pol  = comp_dir;
        st_nxt.long_seen = 2'h0;
      end
    end else if (st_r.long_seen == 2'h3) begin
      st_nxt.ovl        = 1'b0;
      st_nxt.short_cnt0 = 2'h0;
      st_nxt.short_cnt1 = 2'h0;
    end

    // Comparator stuck low
    if (trip_s) begin
      st_nxt.low_cnt = 12'h000;
    end else if (!stuck) begin
      st_nxt.low_cnt = st_r.low_cnt + 12'h001;
    end

    // Comparator period, rising edge to rising edge
    if (trip_rise) begin
      st_nxt.pcnt = 8'h00;
      if (st_r.pcnt < 8'(`POFM_PER_MIN_CYC - 1)) begin
        st_nxt.fast_cnt = fast ? st_r.fast_cnt : st_r.fast_cnt + 2'h1;
      end else begin
        st_nxt.fast_cnt = 2'h0;
      end
    end else if (st_r.pcnt != 8'hFF) begin
      st_nxt.pcnt = st_r.pcnt + 8'h01;
    end

    // Coil wire-break check, only while enabled and a driver sits low
    if (!chk_s || !near_s || cur_ok_s) begin
      st_nxt.wire_cnt = 14'h0000;
    end else if (!wire_brk) begin
      st_nxt.wire_cnt = st_r.wire_cnt + 14'h0001;
    end

    // Registered outputs
    st_nxt.pwm      = st_nxt.drive_pol;
    st_nxt.pwm_n    = !st_nxt.drive_pol;
    st_nxt.comp_pol = st_nxt.ovl ? st_nxt.held_pol : comp_dir;
    st_nxt.comp_en  = !stuck;
    st_nxt.err_oe_n = !(stuck || fast || wire_brk);
    st_nxt.gain     = gain_s;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r          <= '0;
      st_r.pwm_n    <= 1'b1;
      st_r.err_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pin only ever pulls low; high level comes from the board
  assign probe_drive    = st_r.drive_pol;
  assign pwm_out        = st_r.pwm;
  assign pwm_out_n      = st_r.pwm_n;
  assign overload_latch = st_r.ovl;
  assign comp_polarity  = st_r.comp_pol;
  assign comp_enable    = st_r.comp_en;
  assign gain_reduce    = st_r.gain;
  assign error_pin_o    = 1'b0;
  assign error_pin_oe_n = st_r.err_oe_n;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_min_half_len: assert property ($changed(st_r.drive_pol) |->
    $past(st_r.hcnt) >= 8'(`POFM_HALF_MIN_CYC - 1)) else $error("half period too short");
  a_ovl_entry: assert property ($rose(st_r.ovl) |->
    (st_r.short_cnt0 == 2'h3 || st_r.short_cnt1 == 2'h3)) else $error("latch without shorts");
  a_ovl_hold_pol: assert property (st_r.ovl && $past(st_r.ovl) |->
    $stable(st_r.held_pol) ##1 (comp_polarity == st_r.held_pol || !st_r.ovl))
    else $error("held polarity lost");
  a_ovl_exit: assert property ($fell(st_r.ovl) |->
    $past(st_r.long_seen) == 2'h3) else $error("latch left early");
  a_stuck_err: assert property (st_r.low_cnt > 12'(`POFM_LOW_MAX_CYC) |=>
    !error_pin_oe_n && !comp_enable) else $error("stuck comparator not flagged");
  a_fast_err: assert property (st_r.fast_cnt == 2'h3 |=> !error_pin_oe_n)
    else $error("fast period not flagged");
  a_wire_err: assert property (st_r.wire_cnt == 14'(WIRE_MIN_CYC) |=>
    !error_pin_oe_n) else $error("wire break not flagged");
  a_wire_off: assert property (!chk_s |=> st_r.wire_cnt == 14'h0000)
    else $error("wire check active while disabled");
  a_err_release: assert property (!stuck && !fast && !wire_brk |=> error_pin_oe_n)
    else $error("error held without fault");
  a_pwm_pair: assert property (pwm_out_n == !pwm_out)
    else $error("pwm pair not complementary");
  a_gain_follow: assert property (##1 gain_reduce == $past(gain_s))
    else $error("gain reduce not following pin");

  c_ovl_enter: cover property ($rose(st_r.ovl));
  c_ovl_leave: cover property ($fell(st_r.ovl));
  c_stuck: cover property ($rose(stuck));
  c_wire: cover property ($rose(wire_brk));
  c_fast: cover property ($rose(fast));

endmodule : pofm_monitor

// file: logic/pofm_pkg.sv
// Types shared by the probe overload and fault monitor.
// Counter widths are sized for the default timing at 100 MHz.
package pofm_pkg;

  // ----------------------------------------------------------------
  // Monitor state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        drive_pol;   // Probe excitation polarity
    logic [7:0]  hcnt;        // Cycles in current half-period
    logic        cur_short;   // Trip seen before minimum half
    logic        trip_d;      // Comparator delayed for edge
    logic [1:0]  short_cnt0;  // Consecutive short halves, pol 0
    logic [1:0]  short_cnt1;  // Consecutive short halves, pol 1
    logic [1:0]  long_seen;   // Long half seen per polarity
    logic        ovl;         // Overload latch
    logic        held_pol;    // Stored compensation polarity
    logic [11:0] low_cnt;     // Comparator low time
    logic [7:0]  pcnt;        // Comparator period
    logic [1:0]  fast_cnt;    // Consecutive fast periods
    logic [13:0] wire_cnt;    // Coil undercurrent time
    logic        pwm;
    logic        pwm_n;
    logic        comp_pol;
    logic        comp_en;
    logic        err_oe_n;
    logic        gain;
  } pofm_state_t;

endpackage : pofm_pkg

// file: logic/pofm_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes inputs are asynchronous to core_clk; reset is already synchronised.
`timescale 1ns/1ps

module pofm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } pofm_sync_t;

  pofm_sync_t st_r;
  pofm_sync_t st_nxt;

  // First stage feeds only the second; change taken once 2 and 3 agree
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;

endmodule : pofm_sync

// file: sim/pofm_monitor_tb_top.sv
// Self-checking bench for the probe overload and fault monitor.
// Assumes the monitor design files and the probe model are compiled before it.
`timescale 1ns/1ps

module pofm_monitor_tb_top;
  localparam int WIRE_CYC = 50;   // Small wire-break time keeps the run short
  localparam int OVL = 2;
  localparam int ERR = 1;
  localparam int GN  = 0;

  logic       core_clk, nrst, probe_trip, near_a, near_b, coil_ok, chk_en, gain_sel, comp_dir;
  logic       probe_drive, pwm_out, pwm_out_n, overload_latch, comp_polarity;
  logic       comp_enable, gain_reduce, error_pin_o, error_pin_oe_n, err_wire;
  logic [1:0] mode;
  logic [7:0] trip;
  logic [2:0] obs;
  int         mismatches, total_checks, half_len, min_half, flips;

  // ----------------------------------------------------------------
  // Wiring
  // ----------------------------------------------------------------
  // Board pull-up: the monitor only ever pulls the wire low
  assign err_wire = error_pin_oe_n ? 1'b1 : error_pin_o;
  assign obs = {overload_latch, error_pin_oe_n, gain_reduce};

  pofm_monitor #(.WIRE_MIN_CYC(WIRE_CYC)) pofm_monitor_i (
    .core_clk(core_clk), .nrst(nrst), .probe_comparator_out(probe_trip),
    .comp_near_gnd_a(near_a), .comp_near_gnd_b(near_b), .coil_current_ok(coil_ok),
    .coil_check_enable(chk_en), .gain_select(gain_sel), .comp_dir(comp_dir),
    .error_pin_i(err_wire), .probe_drive(probe_drive), .pwm_out(pwm_out),
    .pwm_out_n(pwm_out_n), .overload_latch(overload_latch), .comp_polarity(comp_polarity),
    .comp_enable(comp_enable), .gain_reduce(gain_reduce), .error_pin_o(error_pin_o),
    .error_pin_oe_n(error_pin_oe_n));

  pofm_probe_model pofm_probe_model_i (
    .core_clk(core_clk), .probe_drive(probe_drive), .mode(mode), .trip_cyc(trip),
    .probe_comparator_out(probe_trip));

  // ----------------------------------------------------------------
  // Clock, half-period tracking, PWM pair
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Pair and open-drain level checked at the settled falling edge
  always @(negedge core_clk) begin
    if (nrst) begin
      check("pwm pair", ~pwm_out_n, pwm_out);
      check("pwm follows probe", probe_drive, pwm_out);
      check("error level", 1'b0, error_pin_o);
    end
  end

  // Sampled before the edge updates land, so lengths are whole cycles
  logic drive_q;
  always @(posedge core_clk) begin
    if (probe_drive !== drive_q) begin
      if (half_len < min_half) min_half = half_len;
      flips++;
      half_len = 1;
    end else begin
      half_len++;
    end
    drive_q = probe_drive;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %b, seen %b", name, exp, got);
    end
  endtask : check

  task automatic run(input int n);
    repeat (n) @(negedge core_clk);
  endtask : run

  // Bounded wait on one observed output, then compare it
  task automatic wait_bit(input string name, input int idx, input logic val, input int lim);
    int n;
    n = 0;
    while (obs[idx] !== val && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    check(name, val, obs[idx]);
  endtask : wait_bit

  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  // Watchdog: the whole sequence needs under 6000 cycles
  initial begin
    repeat (10000) @(posedge core_clk);
    mismatches++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst, near_a, near_b, coil_ok, chk_en, gain_sel, comp_dir} = 7'h08;
    mode = 2'h0;
    trip = 8'h28;
    drive_q = 1'b0;
    half_len = 0;
    min_half = 999;
    flips = 0;
    run(12);
    check("pwm_out", 1'b0, pwm_out);
    check("pwm_out_n", 1'b1, pwm_out_n);
    check("error_pin_oe_n", 1'b1, error_pin_oe_n);
    nrst = 1'b1;
    comp_dir = 1'b1;
    run(300);
    check("overload idle", 1'b0, overload_latch);
    // Early trips: halves must still last the minimum
    trip = 8'h0A;
    min_half = 999;
    wait_bit("overload entry", OVL, 1'b1, 300);
    check("min half", 1'b1, min_half >= 28);
    comp_dir = 1'b0;
    flips = 0;
    run(150);
    check("held polarity", 1'b1, comp_polarity);
    check("pwm still runs", 1'b1, flips > 2);
    trip = 8'h28;
    wait_bit("overload exit", OVL, 1'b0, 400);
    run(10);
    check("polarity follows", 1'b0, comp_polarity);
    gain_sel = 1'b1;
    wait_bit("gain reduce on", GN, 1'b1, 10);
    gain_sel = 1'b0;
    wait_bit("gain reduce off", GN, 1'b0, 10);
    // Stuck-low comparator: quiet just short of the limit, then error
    mode = 2'h2;
    run(3150);
    check("stuck early", 1'b1, error_pin_oe_n);
    wait_bit("stuck error", ERR, 1'b0, 100);
    check("comp disabled", 1'b0, comp_enable);
    mode = 2'h0;
    wait_bit("stuck release", ERR, 1'b1, 50);
    check("comp enabled", 1'b1, comp_enable);
    // Too-fast comparator, then a reset in mid-fault
    mode = 2'h1;
    wait_bit("fast error", ERR, 1'b0, 200);
    nrst = 1'b0;
    run(2);
    check("reset drops error", 1'b1, error_pin_oe_n);
    mode = 2'h0;
    nrst = 1'b1;
    run(400);
    // Wire break on each drive output, first with the check disabled
    for (int i = 0; i < 2; i++) begin
      near_a = (i == 0);
      near_b = (i == 1);
      coil_ok = 1'b0;
      chk_en = 1'b0;
      run(2 * WIRE_CYC + 20);
      check("check disabled", 1'b1, error_pin_oe_n);
      chk_en = 1'b1;
      run(WIRE_CYC - 10);
      check("wire early", 1'b1, error_pin_oe_n);
      wait_bit("wire error", ERR, 1'b0, 40);
      coil_ok = 1'b1;
      wait_bit("wire release", ERR, 1'b1, 20);
    end
    summarize();
  end
endmodule : pofm_monitor_tb_top

// file: sim/pofm_probe_model.sv
// Behavioural model of the probe coil as seen through its current comparator.
// Assumes probe_drive comes from the monitor; the output moves at the falling edge.
`timescale 1ns/1ps

module pofm_probe_model (
  input  wire logic       core_clk,
  input  wire logic       probe_drive,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] trip_cyc,
  output logic            probe_comparator_out
);
  logic       last_drive;
  logic [7:0] age;
  logic [3:0] free_cnt;

  // ----------------------------------------------------------------
  // Comparator
  // ----------------------------------------------------------------
  // Mode 0 trips trip_cyc cycles after each drive flip, mode 1 free-runs
  // with a 16-cycle period, mode 2 stays low as with an open probe
  initial begin
    probe_comparator_out = 1'b0;
    last_drive = 1'b0;
    age = 8'h00;
    free_cnt = 4'h0;
  end

  always @(negedge core_clk) begin
    if (probe_drive !== last_drive) begin
      age = 8'h00;                    // Flip restarts the coil current
    end else if (age != 8'hFF) begin
      age = age + 8'h01;
    end
    last_drive = probe_drive;
    free_cnt = free_cnt + 4'h1;
    case (mode)
      2'h0: probe_comparator_out = (age >= trip_cyc);
      2'h1: probe_comparator_out = free_cnt[3];
      default: probe_comparator_out = 1'b0;
    endcase
  end
endmodule : pofm_probe_model
